// *** design/icc_isa_config.sv ***
// isa auto-configuration front end: ports, key, isolation, card handle
`timescale 1ns/1ns
module icc_isa_config #(
  // arbitrary identity values, replace per product
  parameter logic [31:0] VENDOR_ID = 32'h0a5c_3e01,
  parameter logic [31:0] UNIQUE_ID = 32'h0000_0001
) (
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic [11:0] ISA_SA_I,
  input  wire logic        ISA_IOR_N_I,
  input  wire logic        ISA_IOW_N_I,
  input  wire logic        ISA_RESET_DRV_I,
  input  wire logic [7:0]  ISA_D_I,
  output logic      [7:0]  ISA_D_O,
  output logic             ISA_D_OE_N_O,
  input  wire logic        BOOT_NET_I,
  output logic             DEV_ACTIVE_O,
  output logic             CFG_MODE_O,
  output logic      [7:0]  CARD_HANDLE_O
);

  ////////////////////////////////////////////////////////////////////////////
  // state and pin carrier

  icc_pkg::icc_main_s q;
  icc_pkg::icc_main_s n;
  icc_pkg::icc_isa_s  pins;

  logic        ior_fall;
  logic        ior_rise;
  logic        iow_rise;
  logic        bus_rst;
  logic [11:0] rd_port_addr;
  logic        rdp_start;
  logic        rdp_end;
  logic        adr_end;
  logic        wrp_end;
  logic        key_wr;
  logic        key_acc;
  logic        key_hit;
  logic        id_bit;
  logic        id_load;
  logic        id_adv;
  logic        iso_sel;
  logic        sense_ok;

  assign pins = '{addr: ISA_SA_I, data: ISA_D_I, rd_n: ISA_IOR_N_I,
                  wr_n: ISA_IOW_N_I, rst: ISA_RESET_DRV_I,
                  boot: BOOT_NET_I};

  ////////////////////////////////////////////////////////////////////////////
  // strobe edges and port decode
  // edges compare stages two and three; stage three still holds the address
  // and data seen while the strobe was low, so a closing edge uses it

  assign ior_fall = q.s3.rd_n & ~q.s2.rd_n;
  assign ior_rise = ~q.s3.rd_n & q.s2.rd_n;
  assign iow_rise = ~q.s3.wr_n & q.s2.wr_n;
  assign bus_rst  = q.s2.rst;

  assign rd_port_addr = {icc_pkg::RD_ADDR_HI, q.rd_base,
                         icc_pkg::RD_ADDR_LO};

  assign rdp_start = q.s2.addr == rd_port_addr;
  assign rdp_end   = q.s3.addr == rd_port_addr;
  assign adr_end   = q.s3.addr == icc_pkg::ADDR_PORT_LOC;
  assign wrp_end   = q.s3.addr == icc_pkg::WRITE_PORT_LOC;

  // key bytes are only looked for while no configuration session is open
  assign key_wr  = iow_rise & adr_end & (q.st == icc_pkg::ST_WAIT_KEY);
  assign key_acc = ior_rise & adr_end & (q.st == icc_pkg::ST_WAIT_KEY);

  assign iso_sel = (q.st == icc_pkg::ST_ISOLATE) & ~q.winner &
                   (q.index == icc_pkg::REG_ISOLATE);

  // only the two low lines are looked at while listening
  assign sense_ok = q.s3.data[1:0] == (q.second ?
                    icc_pkg::ISO_SENSE_SECOND :
                    icc_pkg::ISO_SENSE_FIRST);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  icc_key_det u_key (
    .clk_i     (SYS_CLK_I),
    .rst_n_i   (RST_N_I),
    .restart_i (bus_rst),
    .wr_i      (key_wr),
    .acc_i     (key_acc),
    .data_i    (q.s3.data),
    .key_o     (key_hit)
  );

  icc_id_shift #(
    .VENDOR_ID (VENDOR_ID),
    .UNIQUE_ID (UNIQUE_ID)
  ) u_id (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (RST_N_I),
    .load_i  (id_load),
    .adv_i   (id_adv),
    .bit_o   (id_bit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    n = q;
    id_load = 1'b0;
    id_adv = 1'b0;

    n.s1 = pins;
    n.s2 = q.s1;
    n.s3 = q.s2;

    // strap settles through the synchroniser before it is trusted
    // stage two only holds the strap from the second edge after release
    if (q.strap_cnt != 2'(icc_pkg::STRAP_SETTLE + 2'h1)) begin
      n.strap_cnt = 2'(q.strap_cnt + 2'h1);
    end
    if (q.strap_cnt == icc_pkg::STRAP_SETTLE) begin
      n.strap = q.s2.boot;
      n.active = q.s2.boot;
    end

    // ---- isolation read cycle: start
    if (ior_fall && rdp_start && iso_sel) begin
      n.in_read = 1'b1;
      if (!q.dropped) begin
        if (id_bit) begin
          n.dout = q.second ? icc_pkg::ISO_DRIVE_SECOND :
                              icc_pkg::ISO_DRIVE_FIRST;
          n.oe_n = 1'b0;
        end else begin
          n.sensing = 1'b1;
        end
      end
    end

    // ---- isolation read cycle: end
    if (ior_rise && q.in_read) begin
      n.in_read = 1'b0;
      n.oe_n = 1'b1;
      n.sensing = 1'b0;
      n.second = ~q.second;
      if (!q.second) begin
        n.hit_first = q.sensing & sense_ok;
      end else begin
        n.hit_first = 1'b0;
        n.pair_cnt = 7'(q.pair_cnt + 7'h01);
        if (!q.dropped) begin
          if (q.sensing && q.hit_first && sense_ok) begin
            n.dropped = 1'b1;
          end else begin
            id_adv = 1'b1;
          end
        end
        if (q.pair_cnt == icc_pkg::ID_LAST_PAIR) begin
          // a card still in at the end of the pass is the one isolated
          n.winner = ~(q.dropped |
                       (q.sensing & q.hit_first & sense_ok));
          n.dropped = 1'b0;
          n.pair_cnt = 7'h00;
          id_load = 1'b1;
        end
      end
    end

    // ---- address port: register index
    if (iow_rise && adr_end && q.st != icc_pkg::ST_WAIT_KEY) begin
      n.index = q.s3.data;
    end

    // ---- write port: data to the indexed register
    if (iow_rise && wrp_end && q.st != icc_pkg::ST_WAIT_KEY) begin
      case (q.index)
        icc_pkg::REG_SET_RD_PORT: begin
          n.rd_base = q.s3.data;
        end
        icc_pkg::REG_HANDLE: begin
          if (q.st == icc_pkg::ST_ISOLATE && q.winner) begin
            n.handle = q.s3.data;
            n.winner = 1'b0;
            n.st = icc_pkg::ST_CONFIG;
          end
        end
        icc_pkg::REG_CFG_CTRL: begin
          // control commands are refused until a handle is held
          if (q.handle != icc_pkg::HANDLE_RESET) begin
            if (q.s3.data[icc_pkg::CTRL_RESET_BIT]) begin
              n.active = q.strap;
              n.rd_base = icc_pkg::RD_BASE_RESET;
            end
            if (q.s3.data[icc_pkg::CTRL_CLR_HANDLE]) begin
              n.handle = icc_pkg::HANDLE_RESET;
            end
            if (q.s3.data[icc_pkg::CTRL_WAIT_BIT]) begin
              n.st = icc_pkg::ST_WAIT_KEY;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // ---- key found: open a session
    if (key_hit && q.st == icc_pkg::ST_WAIT_KEY) begin
      // a card holding a handle sits out isolation entirely
      n.st = (q.handle == icc_pkg::HANDLE_RESET) ?
             icc_pkg::ST_ISOLATE : icc_pkg::ST_CONFIG;
      n.pair_cnt = 7'h00;
      n.second = 1'b0;
      n.dropped = 1'b0;
      n.winner = 1'b0;
      id_load = 1'b1;
    end

    // ---- leaving isolation mid read must not leave the bus driven
    if (n.st != icc_pkg::ST_ISOLATE) begin
      n.in_read = 1'b0;
      n.sensing = 1'b0;
      n.oe_n = 1'b1;
    end

    // ---- isa bus reset overrides everything
    if (bus_rst) begin
      n.st = icc_pkg::ST_WAIT_KEY;
      n.handle = icc_pkg::HANDLE_RESET;
      n.index = icc_pkg::INDEX_RESET;
      n.rd_base = icc_pkg::RD_BASE_RESET;
      n.active = q.strap;
      n.pair_cnt = 7'h00;
      n.second = 1'b0;
      n.in_read = 1'b0;
      n.sensing = 1'b0;
      n.hit_first = 1'b0;
      n.dropped = 1'b0;
      n.winner = 1'b0;
      n.oe_n = 1'b1;
      id_load = 1'b1;
    end

    n.cfg = n.st != icc_pkg::ST_WAIT_KEY;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      q <= icc_pkg::MAIN_RESET;
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  // the driver lets go on the third clock edge after the read strobe rises; the isa
  // data hold window covers this at 10 mhz, faster clocks would shrink it

  assign ISA_D_O       = q.dout;
  assign ISA_D_OE_N_O  = q.oe_n;
  assign DEV_ACTIVE_O  = q.active;
  assign CFG_MODE_O    = q.cfg;
  assign CARD_HANDLE_O = q.handle;

endmodule

// *** design/icc_pkg.sv ***
// package: constants, carriers and state records of the isa config front end
package icc_pkg;

  localparam logic [11:0] ADDR_PORT_LOC  = 12'h279;
  localparam logic [11:0] WRITE_PORT_LOC = 12'ha79;
  localparam logic [1:0]  RD_ADDR_HI     = 2'h0;
  localparam logic [1:0]  RD_ADDR_LO     = 2'h3;
  localparam logic [7:0]  RD_BASE_RESET  = 8'h80;

  localparam logic [7:0]  REG_SET_RD_PORT = 8'h00;
  localparam logic [7:0]  REG_ISOLATE     = 8'h01;
  localparam logic [7:0]  REG_CFG_CTRL    = 8'h02;
  localparam logic [7:0]  REG_HANDLE      = 8'h06;
  localparam int          CTRL_RESET_BIT  = 0;
  localparam int          CTRL_WAIT_BIT   = 1;
  localparam int          CTRL_CLR_HANDLE = 2;

  localparam logic [7:0]  ISO_DRIVE_FIRST  = 8'h55;
  localparam logic [7:0]  ISO_DRIVE_SECOND = 8'haa;
  localparam logic [1:0]  ISO_SENSE_FIRST  = 2'h1;
  localparam logic [1:0]  ISO_SENSE_SECOND = 2'h2;
  localparam logic [6:0]  ID_LAST_PAIR     = 7'h47;
  localparam logic [6:0]  ID_BODY_BITS     = 7'h40;

  localparam logic [7:0]  LFSR_SEED = 8'h6a;
  localparam logic [4:0]  KEY_LAST  = 5'h1f;
  localparam logic [1:0]  STRAP_SETTLE = 2'h2;
  localparam logic [7:0]  HANDLE_RESET = 8'h00;
  localparam logic [7:0]  INDEX_RESET  = 8'h00;

  typedef enum logic [1:0] {
    ST_WAIT_KEY,
    ST_ISOLATE,
    ST_CONFIG
  } icc_state_e;

  // sampled isa pins travel together through the synchroniser
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  data;
    logic        rd_n;
    logic        wr_n;
    logic        rst;
    logic        boot;
  } icc_isa_s;

  localparam icc_isa_s ISA_IDLE = '{addr: 12'h000, data: 8'h00,
    rd_n: 1'b1, wr_n: 1'b1, rst: 1'b0, boot: 1'b0};

  typedef struct packed {
    icc_isa_s   s1;
    icc_isa_s   s2;
    icc_isa_s   s3;
    icc_state_e st;
    logic       cfg;
    logic [7:0] index;
    logic [7:0] rd_base;
    logic [7:0] handle;
    logic [1:0] strap_cnt;
    logic       strap;
    logic       active;
    logic [6:0] pair_cnt;
    logic       second;
    logic       in_read;
    logic       sensing;
    logic       hit_first;
    logic       dropped;
    logic       winner;
    logic [7:0] dout;
    logic       oe_n;
  } icc_main_s;

  localparam icc_main_s MAIN_RESET = '{s1: ISA_IDLE, s2: ISA_IDLE,
    s3: ISA_IDLE, st: ST_WAIT_KEY, cfg: 1'b0, index: INDEX_RESET,
    rd_base: RD_BASE_RESET, handle: HANDLE_RESET, strap_cnt: 2'h0,
    strap: 1'b0, active: 1'b0, pair_cnt: 7'h00, second: 1'b0,
    in_read: 1'b0, sensing: 1'b0, hit_first: 1'b0, dropped: 1'b0,
    winner: 1'b0, dout: 8'h00, oe_n: 1'b1};

  typedef struct packed {
    logic [7:0] nxt_byte;
    logic [4:0] cnt;
    logic       hit;
  } icc_key_s;

  typedef struct packed {
    logic [63:0] sr;
    logic [7:0]  chk;
    logic [6:0]  idx;
  } icc_id_s;

  // one step of the shared key / checksum shift register
  function automatic logic [7:0] lfsr_step(input logic [7:0] l,
                                           input logic       b);
    lfsr_step = {l[1] ^ l[0] ^ b, l[7:1]};
  endfunction

endpackage

// *** design/icc_key_det.sv ***
// initiation key matcher fed by address port writes
`timescale 1ns/1ns
module icc_key_det (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       restart_i,
  input  wire logic       wr_i,
  input  wire logic       acc_i,
  input  wire logic [7:0] data_i,
  output logic            key_o
);

  icc_pkg::icc_key_s q;
  icc_pkg::icc_key_s n;

  always_comb begin
    n = q;
    n.hit = 1'b0;
    if (restart_i || acc_i) begin
      n.nxt_byte = icc_pkg::LFSR_SEED;
      n.cnt = 5'h00;
    end else if (wr_i) begin
      if (data_i == q.nxt_byte) begin
        n.nxt_byte = icc_pkg::lfsr_step(q.nxt_byte, 1'b0);
        n.cnt = 5'(q.cnt + 5'h01);
        if (q.cnt == icc_pkg::KEY_LAST) begin
          n.hit = 1'b1;
          n.nxt_byte = icc_pkg::LFSR_SEED;
          n.cnt = 5'h00;
        end
      end else if (data_i == icc_pkg::LFSR_SEED) begin
        // a stray first byte starts a fresh attempt rather than wasting it
        n.nxt_byte = icc_pkg::lfsr_step(icc_pkg::LFSR_SEED, 1'b0);
        n.cnt = 5'h01;
      end else begin
        n.nxt_byte = icc_pkg::LFSR_SEED;
        n.cnt = 5'h00;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '{nxt_byte: icc_pkg::LFSR_SEED, cnt: 5'h00, hit: 1'b0};
    end else begin
      q <= n;
    end
  end

  assign key_o = q.hit;

endmodule

// *** design/icc_id_shift.sv ***
// serial identifier shifter with checksum built while shifting
`timescale 1ns/1ns
module icc_id_shift #(
  parameter logic [31:0] VENDOR_ID = 32'h0a5c_3e01,
  parameter logic [31:0] UNIQUE_ID = 32'h0000_0001
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic load_i,
  input  wire logic adv_i,
  output logic      bit_o
);

  icc_pkg::icc_id_s q;
  icc_pkg::icc_id_s n;

  always_comb begin
    n = q;
    if (load_i) begin
      n.sr = {UNIQUE_ID, VENDOR_ID};
      n.chk = icc_pkg::LFSR_SEED;
      n.idx = 7'h00;
    end else if (adv_i) begin
      if (q.idx < icc_pkg::ID_BODY_BITS) begin
        n.chk = icc_pkg::lfsr_step(q.chk, q.sr[0]);
        n.sr = {1'b0, q.sr[63:1]};
      end else begin
        n.chk = {1'b0, q.chk[7:1]};
      end
      n.idx = 7'(q.idx + 7'h01);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '{sr: {UNIQUE_ID, VENDOR_ID}, chk: icc_pkg::LFSR_SEED,
             idx: 7'h00};
    end else begin
      q <= n;
    end
  end

  assign bit_o = (q.idx < icc_pkg::ID_BODY_BITS) ? q.sr[0] : q.chk[0];

endmodule

// *** test/icc_isa_config_assertions.sv ***
// checker: port-level properties of the isa config front end
`timescale 1ns/1ns
module icc_isa_config_chk (
  input wire logic        SYS_CLK_I,
  input wire logic        RST_N_I,
  input wire logic [11:0] ISA_SA_I,
  input wire logic        ISA_IOR_N_I,
  input wire logic        ISA_IOW_N_I,
  input wire logic        ISA_RESET_DRV_I,
  input wire logic [7:0]  ISA_D_I,
  input wire logic [7:0]  ISA_D_O,
  input wire logic        ISA_D_OE_N_O,
  input wire logic        BOOT_NET_I,
  input wire logic        DEV_ACTIVE_O,
  input wire logic        CFG_MODE_O,
  input wire logic [7:0]  CARD_HANDLE_O
);
  // clocks since the last write strobe ended, saturating
  logic [2:0] iow_age_q;

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      iow_age_q <= 3'h7;
    end else if (!ISA_IOW_N_I) begin
      iow_age_q <= 3'h0;
    end else if (iow_age_q != 3'h7) begin
      iow_age_q <= iow_age_q + 3'h1;
    end
  end

  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);

  key_gates_cfg_a: assert property ($rose(CFG_MODE_O) |->
    iow_age_q <= 3'h5)
    else $error("config mode entered without a port write");
  bus_reset_a: assert property (ISA_RESET_DRV_I [*4] |-> ##[0:2]
    (!CFG_MODE_O && CARD_HANDLE_O == 8'h00))
    else $error("bus reset left mode or handle set");
  strap_active_a: assert property ($rose(DEV_ACTIVE_O) |-> BOOT_NET_I)
    else $error("card became active without strap");
  drive_value_a: assert property (!ISA_D_OE_N_O |->
    (ISA_D_O == 8'h55 || ISA_D_O == 8'haa))
    else $error("driven byte is not an isolation pattern");
  drive_gate_a: assert property (!ISA_D_OE_N_O |->
    (CFG_MODE_O && CARD_HANDLE_O == 8'h00))
    else $error("bus driven outside isolation");
  drive_on_read_a: assert property ($fell(ISA_D_OE_N_O) |->
    $past(ISA_IOR_N_I, 2) == 1'b0)
    else $error("bus driven without a read cycle");
  release_bus_a: assert property ($rose(ISA_IOR_N_I) |->
    ##[1:4] ISA_D_OE_N_O)
    else $error("bus still driven after read");
  hold_drive_a: assert property ((!ISA_D_OE_N_O && !ISA_IOR_N_I) |=>
    $stable(ISA_D_O))
    else $error("driven byte changed inside a read");
  handle_cfg_a: assert property (($changed(CARD_HANDLE_O) &&
    CARD_HANDLE_O != 8'h00) |-> CFG_MODE_O)
    else $error("handle assigned outside configuration");
endmodule

bind icc_isa_config icc_isa_config_chk u_chk (
  .SYS_CLK_I, .RST_N_I, .ISA_SA_I, .ISA_IOR_N_I, .ISA_IOW_N_I,
  .ISA_RESET_DRV_I, .ISA_D_I, .ISA_D_O, .ISA_D_OE_N_O, .BOOT_NET_I,
  .DEV_ACTIVE_O, .CFG_MODE_O, .CARD_HANDLE_O
);

// *** test/icc_rival_card.sv ***
// competing card on the isa data bus that contests isolation pairs
`timescale 1ns/1ns
module icc_rival_card (
  input  wire logic       rst_n_i,
  input  wire logic       ior_n_i,
  input  wire logic       sel_i,
  input  wire logic       bit_i,
  output logic      [7:0] d_o,
  output logic            oe_n_o
);
  logic second_q;

  always @(posedge ior_n_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      second_q <= 1'b0;
    end else if (sel_i && bit_i) begin
      second_q <= ~second_q;
    end
  end

  // whole byte driven, only while its bit is one and the read lasts
  assign d_o    = second_q ? 8'haa : 8'h55;
  assign oe_n_o = ~(sel_i & bit_i & ~ior_n_i);
endmodule

// *** test/icc_isa_config_bench.sv ***
// self-checking bench for the isa config front end
`timescale 1ns/1ns
module icc_isa_config_bench;
  // arbitrary identity values
  localparam logic [31:0] VEND = 32'h1357_9bdf;
  localparam logic [31:0] UNIQ = 32'h2468_ace1;
  localparam logic [7:0]  KEY [32] = '{8'h6a, 8'hb5, 8'hda, 8'hed, 8'hf6,
    8'hfb, 8'h7d, 8'hbe, 8'hdf, 8'h6f, 8'h37, 8'h1b, 8'h0d, 8'h86, 8'hc3,
    8'h61, 8'hb0, 8'h58, 8'h2c, 8'h16, 8'h8b, 8'h45, 8'ha2, 8'hd1, 8'he8,
    8'h74, 8'h3a, 8'h9d, 8'hce, 8'he7, 8'h73, 8'h39};
  logic        clk, rst_n, iow_n, ior_n, bus_rst, boot, riv_on, riv_oe_n;
  logic        oe_n, active, cfg, e;
  logic [11:0] sa, rd_port;
  logic [7:0]  d_wr, d_bus, d_o, handle, riv_d, v, c;
  logic [71:0] id;
  int          mismatches, checked;

  // undriven data lines are held high by the bus pull-ups
  assign d_bus = (oe_n ? 8'hff : d_o) & (riv_oe_n ? 8'hff : riv_d)
    & (iow_n ? 8'hff : d_wr);

  icc_isa_config #(.VENDOR_ID(VEND), .UNIQUE_ID(UNIQ)) dut (
    .SYS_CLK_I(clk), .RST_N_I(rst_n), .ISA_SA_I(sa), .ISA_IOR_N_I(ior_n),
    .ISA_IOW_N_I(iow_n), .ISA_RESET_DRV_I(bus_rst), .ISA_D_I(d_bus),
    .ISA_D_O(d_o), .ISA_D_OE_N_O(oe_n), .BOOT_NET_I(boot),
    .DEV_ACTIVE_O(active), .CFG_MODE_O(cfg), .CARD_HANDLE_O(handle));

  icc_rival_card rival (.rst_n_i(rst_n), .ior_n_i(ior_n),
    .sel_i(sa == rd_port), .bit_i(riv_on), .d_o(riv_d), .oe_n_o(riv_oe_n));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic io_wr(input logic [11:0] a, input logic [7:0] dv);
    @(negedge clk);
    sa = a;
    d_wr = dv;
    iow_n = 1'b0;
    repeat (4) @(negedge clk);
    iow_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask

  task automatic io_rd(input logic [11:0] a);
    @(negedge clk);
    sa = a;
    ior_n = 1'b0;
    repeat (4) @(negedge clk);
    v = d_o;
    e = oe_n;
    ior_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask

  // byte number bad is replaced by a wrong value; 32 sends it whole
  task automatic send_key(input logic [11:0] a, input int bad);
    for (int i = 0; i < 32; i++) begin
      io_wr(a, i == bad ? 8'h00 : KEY[i]);
    end
  endtask

  task automatic iso_pass();
    logic dropped;
    logic drv;
    dropped = 1'b0;
    for (int k = 0; k < 72; k++) begin
      drv = id[k] & ~dropped;
      io_rd(rd_port);
      chk("oe first", {7'h00, ~drv}, {7'h00, e});
      if (drv) chk("first", 8'h55, v);
      io_rd(rd_port);
      chk("oe second", {7'h00, ~drv}, {7'h00, e});
      if (drv) chk("second", 8'haa, v);
      if (!id[k] && riv_on) dropped = 1'b1;
      repeat (300) @(negedge clk);
    end
  endtask

  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    $display("watchdog expired");
    stop_test();
  end

  initial begin
    {rst_n, bus_rst, boot, riv_on, sa, d_wr} = '0;
    {iow_n, ior_n} = 2'b11;
    rd_port = 12'h203;
    mismatches = 0;
    checked = 0;
    c = 8'h6a;
    id = {8'h00, UNIQ, VEND};
    for (int i = 0; i < 64; i++) begin
      c = {c[1] ^ c[0] ^ id[i], c[7:1]};
    end
    id[71:64] = c;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("active", 8'h00, {7'h00, active});
    chk("mode", 8'h00, {7'h00, cfg});
    chk("handle", 8'h00, handle);
    io_rd(12'h203);
    chk("idle float", 8'h01, {7'h00, e});
    $display("test reset done");
    send_key(12'h679, 32);
    chk("alias key", 8'h00, {7'h00, cfg});
    send_key(12'h279, 16);
    chk("broken key", 8'h00, {7'h00, cfg});
    send_key(12'h279, 32);
    chk("key", 8'h01, {7'h00, cfg});
    $display("test key done");
    io_wr(12'h279, 8'h00);
    io_wr(12'ha79, 8'hc5);
    rd_port = 12'h317;
    io_wr(12'h279, 8'h01);
    io_rd(12'h203);
    chk("old port", 8'h01, {7'h00, e});
    riv_on = 1'b1;
    iso_pass();
    io_wr(12'h279, 8'h06);
    io_wr(12'ha79, 8'h03);
    chk("loser handle", 8'h00, handle);
    io_wr(12'h279, 8'h01);
    riv_on = 1'b0;
    iso_pass();
    io_wr(12'h279, 8'h06);
    io_wr(12'ha79, 8'h03);
    chk("winner handle", 8'h03, handle);
    io_wr(12'h279, 8'h01);
    io_rd(rd_port);
    chk("handled float", 8'h01, {7'h00, e});
    io_wr(12'h279, 8'h02);
    io_wr(12'ha79, 8'h02);
    chk("wait key mode", 8'h00, {7'h00, cfg});
    chk("kept handle", 8'h03, handle);
    send_key(12'h279, 32);
    chk("handled key", 8'h01, {7'h00, cfg});
    $display("test isolation done");
    bus_rst = 1'b1;
    repeat (5) @(negedge clk);
    bus_rst = 1'b0;
    repeat (4) @(negedge clk);
    chk("bus rst mode", 8'h00, {7'h00, cfg});
    chk("bus rst handle", 8'h00, handle);
    rst_n = 1'b0;
    boot = 1'b1;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    chk("boot active", 8'h01, {7'h00, active});
    $display("test resets done");
    stop_test();
  end
endmodule
